// ---- verilog/stsc_top.sv ----
// file: scroll mapping, tearing sync output and power level tracking
// assumes a wishbone master on clk_i; hw_reset_n_i is an asynchronous pin
// ------------------------------------------------------------
// ports and rule summary
// ------------------------------------------------------------
// What this block does
// - one rolling scroll, two scroll commands
// - heights summing 320 roll whole memory
// - bottom-to-top order swaps fixed areas
// - tearing on and off commands gate sync
// - tearing-on parameter picks sync mode
// - mode 1: high only in vblank
// - mode 2: vblank plus 320 line pulses
// - refresh only while sync line low
// - sleep-in holds sync output low
// - vertical low 13 ms, high 1000 us; the code's low is about 18.6 ms
// - line low 33 us, high 25-500 us
// - hardware reset beats chip select
// - power loss blanks until power-on
// - idle reduces colors to eight
// - partial drives only part of display
// - sleep stops oscillator, keeps memory
// - levels 1-5 by command, 6 unpowered
module stsc_top
  import stsc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hw_reset_n_i,
  input wire logic chip_select_n_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // panel side
  output logic tear_sync_o,
  output logic refresh_o,
  output logic [8:0] panel_row_o,
  output logic [8:0] mem_row_o,
  output logic color_reduce_o,
  output logic row_drive_o,
  output logic osc_run_o,
  output logic blank_o,
  output logic [2:0] power_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // reset pin synchroniser
  // ------------------------------------------------------------
  logic hwr_meta_ff, hwr_sync_ff;
  logic cs_meta_ff, cs_sync_ff;
  // chip select is a pin too, so it takes the same two flops
  always_ff @(posedge clk_i) begin
    hwr_meta_ff <= hw_reset_n_i;
    hwr_sync_ff <= hwr_meta_ff;
    cs_meta_ff <= chip_select_n_i;
    cs_sync_ff <= cs_meta_ff;
  end
  // pin reset overrides bus access regardless of chip select
  logic srst;
  assign srst = rst_i | ~hwr_sync_ff;
  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  stsc_scroll_t scroll_ff;
  logic [31:0] ctrl_ff;
  logic [8:0] part_start_ff, part_end_ff;
  logic ack_ff;
  logic wr_en, acc;
  // chip select only gates bus access, never reset
  assign acc = cyc_i & stb_i & ~ack_ff & ~cs_sync_ff;
  // a write lands on the edge that sees ack high, when the cycle is sure
  // to complete; read data is already registered by then
  assign wr_en = cyc_i & stb_i & ack_ff & we_i & sel_i[0] & ~cs_sync_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= cyc_i & stb_i & ~ack_ff;
    end
  end
  // ack comes even with chip select high, so a master never hangs
  assign ack_o = ack_ff;
  // scroll definition (33h) and start line (37h) registers
  always_ff @(posedge clk_i) begin
    if (srst) begin
      scroll_ff <= '{TOP_FIXED_RST, SCROLL_AREA_RST, BOTTOM_FIXED_RST, 9'h000};
    end else if (wr_en) begin
      case (adr_i)
        ADR_SCROLL_DEF0: begin
          scroll_ff.top_fixed_height <= dat_i[8:0];
          scroll_ff.scroll_area_height <= dat_i[24:16];
        end
        ADR_SCROLL_DEF1: scroll_ff.bottom_fixed_height <= dat_i[8:0];
        ADR_SCROLL_START: scroll_ff.scroll_start_line <= dat_i[8:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst) begin
      ctrl_ff <= CTRL_RESET;
      part_start_ff <= PARTIAL_START_RST;
      part_end_ff <= PARTIAL_END_RST;
    end else if (wr_en) begin
      if (adr_i == ADR_CTRL) begin
        ctrl_ff <= {25'h0, dat_i[6:0]};
      end
      if (adr_i == ADR_MAP) begin
        part_start_ff <= dat_i[8:0];
        part_end_ff <= dat_i[24:16];
      end
    end
  end
  // ------------------------------------------------------------
  // power level
  // ------------------------------------------------------------
  logic sleep_in, powered;
  stsc_level_t level;
  // level is derived, not stored: it always tracks the control bits
  assign powered = ctrl_ff[CTL_POWER_OK];
  assign sleep_in = ~ctrl_ff[CTL_SLEEP_OUT];
  always_comb begin
    if (!powered) begin
      level = STSC_LVL_OFF;
    end else if (sleep_in) begin
      level = STSC_LVL_SLEEP;
    end else begin
      case ({ctrl_ff[CTL_IDLE], ctrl_ff[CTL_PARTIAL]})
        2'b00: level = STSC_LVL_NORMAL;
        2'b01: level = STSC_LVL_PARTIAL;
        2'b10: level = STSC_LVL_IDLE;
        default: level = STSC_LVL_PART_IDLE;
      endcase
    end
  end
  // ------------------------------------------------------------
  // scan timing
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_VBLANK, ST_LINE_LOW, ST_LINE_HIGH} stsc_state_t;
  stsc_state_t state_ff;
  logic [15:0] cnt_ff;
  logic [8:0] row_ff;
  logic scan_run;
  // oscillator off in sleep: scan is held at the start of vblank and restarts there
  assign scan_run = powered & ~sleep_in;
  // ------------------------------------------------------------
  // microsecond tick
  // ------------------------------------------------------------
  // one enable pulse per microsecond paces all scan counters; the divider
  // restarts with the scan so every period is a whole number of ticks
  localparam int unsigned TICK_DIV = CLK_HZ / 1000000;
  logic [5:0] div_ff;
  logic us_tick;
  assign us_tick = (div_ff == 6'(TICK_DIV - 1));
  always_ff @(posedge clk_i) begin
    if (srst || !scan_run || us_tick) begin
      div_ff <= 6'h00;
    end else begin
      div_ff <= div_ff + 6'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst || !scan_run) begin
      state_ff <= ST_VBLANK;
      cnt_ff <= 16'h0000;
      row_ff <= 9'h000;
    end else if (us_tick) begin
      case (state_ff)
        ST_VBLANK: begin
          if (cnt_ff == 16'(VBLANK_US - 1)) begin
            cnt_ff <= 16'h0000;
            row_ff <= 9'h000;
            state_ff <= ST_LINE_LOW;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        ST_LINE_LOW: begin
          if (cnt_ff == 16'(LINE_LOW_US - 1)) begin
            cnt_ff <= 16'h0000;
            state_ff <= ST_LINE_HIGH;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        ST_LINE_HIGH: begin
          if (cnt_ff == 16'(LINE_HIGH_US - 1)) begin
            cnt_ff <= 16'h0000;
            if (row_ff == PANEL_ROWS - 9'h001) begin
              state_ff <= ST_VBLANK;
            end else begin
              row_ff <= row_ff + 9'h001;
              state_ff <= ST_LINE_LOW;
            end
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        default: state_ff <= ST_VBLANK;
      endcase
    end
  end
  // 320 lines of 58 us give about 18.6 ms of vertical low time
  // ------------------------------------------------------------
  // scroll mapping
  // ------------------------------------------------------------
  logic [8:0] upper_fixed, lower_fixed, area_end, offs, wrap, mapped;
  logic [9:0] sum_off;
  // bottom-to-top order exchanges the two fixed areas
  assign upper_fixed = ctrl_ff[CTL_ORDER] ? scroll_ff.bottom_fixed_height
                                          : scroll_ff.top_fixed_height;
  assign lower_fixed = ctrl_ff[CTL_ORDER] ? scroll_ff.top_fixed_height
                                          : scroll_ff.bottom_fixed_height;
  // fixed areas pass panel rows straight through to memory rows
  assign area_end = PANEL_ROWS - lower_fixed;
  assign offs = row_ff - upper_fixed;
  // start line is a memory row inside the scroll area; sum < 320 left undefined
  assign sum_off = {1'b0, scroll_ff.scroll_start_line} + {1'b0, offs};
  assign wrap = (sum_off >= {1'b0, area_end}) ?
                9'(sum_off - {1'b0, scroll_ff.scroll_area_height}) : sum_off[8:0];
  always_comb begin
    if (row_ff < upper_fixed || row_ff >= area_end) begin
      mapped = row_ff;
    end else begin
      mapped = wrap;
    end
  end
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic in_part, drive_now, sync_now;
  // in partial mode, rows outside the partial window get no refresh pulse
  assign in_part = (row_ff >= part_start_ff) && (row_ff <= part_end_ff);
  assign drive_now = (state_ff == ST_LINE_LOW) & scan_run &
                     (~ctrl_ff[CTL_PARTIAL] | in_part);
  // sync and refresh share one register stage, so their edges line up
  always_comb begin
    if (!ctrl_ff[CTL_TEAR_ON] || !scan_run) begin
      sync_now = 1'b0;
    end else if (ctrl_ff[CTL_TEAR_MODE]) begin
      sync_now = (state_ff != ST_LINE_LOW);
    end else begin
      sync_now = (state_ff == ST_VBLANK);
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst) begin
      tear_sync_o <= 1'b0;
      refresh_o <= 1'b0;
      panel_row_o <= 9'h000;
      mem_row_o <= 9'h000;
      color_reduce_o <= 1'b0;
      row_drive_o <= 1'b0;
      osc_run_o <= 1'b0;
      blank_o <= 1'b1;
      power_level_o <= 3'h6;
    end else begin
      tear_sync_o <= sync_now;
      refresh_o <= drive_now;
      panel_row_o <= row_ff;
      mem_row_o <= mapped;
      color_reduce_o <= ctrl_ff[CTL_IDLE];
      row_drive_o <= scan_run;
      osc_run_o <= scan_run;
      blank_o <= ~powered;
      power_level_o <= level;
    end
  end
  // ------------------------------------------------------------
  // read back
  // ------------------------------------------------------------
  // status is a snapshot; the scan moves on right after it is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (acc && !we_i) begin
      case (adr_i)
        ADR_SCROLL_DEF0: dat_o <= {7'h0, scroll_ff.scroll_area_height,
                                   7'h0, scroll_ff.top_fixed_height};
        ADR_SCROLL_DEF1: dat_o <= {23'h0, scroll_ff.bottom_fixed_height};
        ADR_SCROLL_START: dat_o <= {23'h0, scroll_ff.scroll_start_line};
        ADR_CTRL: dat_o <= ctrl_ff;
        ADR_STATUS: dat_o <= {5'h0, level, 2'h0, state_ff, 1'b0, mapped, row_ff, sync_now};
        ADR_MAP: dat_o <= {7'h0, part_end_ff, 7'h0, part_start_ff};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule : stsc_top

// ---- verilog/stsc_pkg.sv ----
// package: constants and types for scroll, tearing sync and power-level logic
// assumes one 50 MHz clock and a classic wishbone register port
package stsc_pkg;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CLK_HZ = 50000000;
  localparam logic [8:0] PANEL_ROWS = 9'h140;
  // command codes for reference; no register carries them, registers are decoded by byte offset
  localparam logic [7:0] CMD_SCROLL_DEF = 8'h33;
  localparam logic [7:0] CMD_SCROLL_START = 8'h37;
  // register byte offsets
  localparam logic [7:0] ADR_SCROLL_DEF0 = 8'h00;
  localparam logic [7:0] ADR_SCROLL_DEF1 = 8'h04;
  localparam logic [7:0] ADR_SCROLL_START = 8'h08;
  localparam logic [7:0] ADR_CTRL = 8'h0c;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_MAP = 8'h14;
  // control register fields
  localparam int CTL_TEAR_ON = 0;
  localparam int CTL_TEAR_MODE = 1;
  localparam int CTL_ORDER = 2;
  localparam int CTL_SLEEP_OUT = 3;
  localparam int CTL_PARTIAL = 4;
  localparam int CTL_IDLE = 5;
  localparam int CTL_POWER_OK = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // reset heights: full-screen scroll area
  localparam logic [8:0] TOP_FIXED_RST = 9'h000;
  localparam logic [8:0] SCROLL_AREA_RST = 9'h140;
  localparam logic [8:0] BOTTOM_FIXED_RST = 9'h000;
  // sync output timing
  localparam int unsigned LINE_LOW_US = 33;
  localparam int unsigned LINE_HIGH_US = 25;
  localparam int unsigned VBLANK_US = 1000;
  localparam int unsigned LINE_LOW_CYC = (LINE_LOW_US * (CLK_HZ / 1000000));
  localparam int unsigned LINE_HIGH_CYC = (LINE_HIGH_US * (CLK_HZ / 1000000));
  localparam int unsigned VBLANK_CYC = (VBLANK_US * (CLK_HZ / 1000000));
  localparam logic [8:0] PARTIAL_START_RST = 9'h000;
  localparam logic [8:0] PARTIAL_END_RST = 9'h13f;

  typedef enum logic [2:0] {
    STSC_LVL_NORMAL = 3'h1,
    STSC_LVL_PARTIAL = 3'h2,
    STSC_LVL_IDLE = 3'h3,
    STSC_LVL_PART_IDLE = 3'h4,
    STSC_LVL_SLEEP = 3'h5,
    STSC_LVL_OFF = 3'h6
  } stsc_level_t;

  typedef struct packed {
    logic [8:0] top_fixed_height;
    logic [8:0] scroll_area_height;
    logic [8:0] bottom_fixed_height;
    logic [8:0] scroll_start_line;
  } stsc_scroll_t;

  typedef struct packed {
    logic sync;
    logic refresh;
    logic [8:0] row;
    logic [8:0] mem_row;
  } stsc_scan_t;
endpackage : stsc_pkg

// ---- verification/stsc_asserts.sv ----
// checker: port relations of stsc_top
// assumes a bind onto stsc_top, one clock, sync reset
module stsc_asserts
  import stsc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // panel side
  input wire logic tear_sync_o,
  input wire logic refresh_o,
  input wire logic [8:0] panel_row_o,
  input wire logic [8:0] mem_row_o,
  input wire logic color_reduce_o,
  input wire logic osc_run_o,
  input wire logic blank_o,
  input wire logic [2:0] power_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  chk_refresh_sync: assert property (refresh_o |-> !tear_sync_o)
    else $error("refresh while sync high");
  chk_sleep_low: assert property (!osc_run_o && $past(!osc_run_o) |-> !tear_sync_o)
    else $error("sync high while stopped");
  chk_idle_colors: assert property (power_level_o inside {STSC_LVL_IDLE,
    STSC_LVL_PART_IDLE} |-> color_reduce_o)
    else $error("idle without reduce");
  chk_full_colors: assert property (power_level_o inside {STSC_LVL_NORMAL,
    STSC_LVL_PARTIAL} |-> !color_reduce_o)
    else $error("reduce outside idle");
  chk_sleep_stop: assert property (power_level_o == STSC_LVL_SLEEP |-> !osc_run_o)
    else $error("oscillator runs in sleep");
  chk_blank_off: assert property (blank_o |-> power_level_o == STSC_LVL_OFF)
    else $error("blank while powered");
  chk_row_range: assert property (panel_row_o < PANEL_ROWS && mem_row_o < PANEL_ROWS)
    else $error("row out of range");
endmodule : stsc_asserts

// ---- verification/stsc_host.sv ----
// host model: classic wishbone master for the microprocessor side
// assumes the device acks on clk_i; released lines show inverted data
module stsc_host (
  // clock
  input wire logic clk_i,
  // wishbone master
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int hangs = 0;
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 64);
    if (n >= 64) hangs++;
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask : xfer
endmodule : stsc_host

// ---- verification/tb_top.sv ----
// bench: scroll map, tearing sync, power levels of stsc_top
// assumes stsc_host as bus master and the bound checker
module tb_top
  import stsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] RUN = (32'h1 << CTL_POWER_OK) | (32'h1 << CTL_SLEEP_OUT);
  localparam logic [31:0] TEAR = 32'h1 << CTL_TEAR_ON;
  localparam logic [31:0] MODE2 = 32'h1 << CTL_TEAR_MODE;
  logic clk_i = 1'b0, rst_i = 1'b1, hw_n = 1'b1, cs_n = 1'b0;
  logic cyc, stb, we, ack, sync, refr, blank, color, osc, rowdrv;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [8:0] prow, mrow;
  logic [2:0] lvl;
  int errors = 0, check_count = 0;
  int cycles = 0;
  initial forever #10 clk_i = ~clk_i;
  // free edge count, for spans that a bus access sits inside
  always @(posedge clk_i) cycles <= cycles + 1;
  stsc_host stsc_host_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  stsc_top stsc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .hw_reset_n_i(hw_n),
    .chip_select_n_i(cs_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .tear_sync_o(sync),
    .refresh_o(refr), .panel_row_o(prow), .mem_row_o(mrow), .color_reduce_o(color),
    .row_drive_o(rowdrv), .osc_run_o(osc), .blank_o(blank), .power_level_o(lvl));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test();
    errors += stsc_host_inst.hangs;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  function automatic logic [8:0] probe(input int k);
    case (k)
      0: return {8'h00, sync};
      1: return {8'h00, refr};
      default: return prow;
    endcase
  endfunction : probe
  // n counts edges waited; a run-out ends the run
  task automatic wait_for(input int k, input logic [8:0] v, output int n);
    n = 0;
    while (probe(k) !== v) begin
      @(posedge clk_i);
      n++;
      if (n > 60000) begin
        chk("wait", 32'h0, 32'h1);
        stop_test();
      end
    end
  endtask : wait_for
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    stsc_host_inst.xfer(1'b1, a, d, q);
    if (stsc_host_inst.hangs != 0) stop_test();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    stsc_host_inst.xfer(1'b0, a, 32'h0, d);
    if (stsc_host_inst.hangs != 0) stop_test();
  endtask : rd
  // ----
  // scenarios
  // ----
  task automatic t_tear_mode1();
    int n;
    int t0;
    wr(ADR_SCROLL_DEF0, {7'h00, 9'h13b, 7'h00, 9'h003});
    wr(ADR_SCROLL_DEF1, 32'h2);
    wr(ADR_SCROLL_START, 32'h13c);
    wr(ADR_CTRL, RUN | TEAR);
    wait_for(0, 9'h001, n);
    t0 = cycles;
    wr(ADR_SCROLL_START, 32'h13c);
    wait_for(0, 9'h000, n);
    n = cycles - t0;
    chk("vblank", 32'h1, 32'(n >= VBLANK_CYC - 1 && n <= VBLANK_CYC + 1));
    repeat (3) @(posedge clk_i);
    chk("refresh", 32'h1, {31'h0, refr});
    wait_for(1, 9'h000, n);
    repeat (3) @(posedge clk_i);
    chk("mode1_line", 32'h0, {31'h0, sync});
  endtask : t_tear_mode1
  task automatic t_tear_mode2();
    int n;
    wr(ADR_CTRL, RUN | TEAR | MODE2);
    wait_for(1, 9'h001, n);
    wait_for(1, 9'h000, n);
    repeat (2) @(posedge clk_i);
    chk("mode2_line", 32'h1, {31'h0, sync});
    wait_for(0, 9'h000, n);
    wait_for(0, 9'h001, n);
    chk("line_low", LINE_LOW_CYC, n);
    wait_for(0, 9'h000, n);
    chk("line_high", LINE_HIGH_CYC, n);
  endtask : t_tear_mode2
  task automatic t_scroll_map();
    int n;
    wait_for(2, 9'h005, n);
    repeat (3) @(posedge clk_i);
    chk("map_wrap", 32'h3, {23'h0, mrow});
    wr(ADR_CTRL, RUN | TEAR | MODE2 | (32'h1 << CTL_ORDER));
    wait_for(2, 9'h007, n);
    repeat (3) @(posedge clk_i);
    chk("map_swap", 32'h6, {23'h0, mrow});
    rd(ADR_SCROLL_DEF0, q);
    chk("def0", {7'h00, 9'h13b, 7'h00, 9'h003}, q);
  endtask : t_scroll_map
  task automatic t_tear_off();
    int n;
    wr(ADR_CTRL, RUN | MODE2);
    wait_for(1, 9'h000, n);
    repeat (3) @(posedge clk_i);
    chk("tear_off", 32'h0, {31'h0, sync});
  endtask : t_tear_off
  task automatic t_power();
    logic [31:0] cv [6];
    int n;
    // power is removed only from sleep-in, so no wait is owed before it
    cv = '{RUN, RUN | 32'h10, RUN | 32'h20, RUN | 32'h30, 32'h40, 32'h0};
    // partial window kept clear of the rows scanned during this task
    wr(ADR_MAP, {7'h00, 9'h13f, 7'h00, 9'h100});
    for (int i = 0; i < 6; i++) begin
      wr(ADR_CTRL, cv[i] | TEAR | MODE2);
      repeat (4) @(posedge clk_i);
      chk("level", i + 1, {29'h0, lvl});
      chk("colors", 32'(i == 2 || i == 3), {31'h0, color});
      chk("osc", 32'(i < 4), {31'h0, osc});
      chk("drive", 32'(i < 4), {31'h0, rowdrv});
      chk("blank", 32'(i == 5), {31'h0, blank});
      if (i == 4) chk("sleep_sync", 32'h0, {31'h0, sync});
      if (i < 2) begin
        wait_for(0, 9'h001, n);
        wait_for(0, 9'h000, n);
        repeat (2) @(posedge clk_i);
        chk("part_drive", 32'(i == 0), {31'h0, refr});
      end
      rd(ADR_STATUS, q);
      chk("status", i + 1, {29'h0, q[26:24]});
    end
  endtask : t_power
  task automatic t_bus();
    cs_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(ADR_SCROLL_START, 32'h055);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(ADR_SCROLL_START, q);
    chk("cs_high", 32'h13c, q);
    rd(8'h40, q);
    chk("unmapped", 32'h0, q);
  endtask : t_bus
  task automatic t_pin_reset();
    wr(ADR_CTRL, RUN);
    hw_n <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk("pin_blank", 32'h1, {31'h0, blank});
    chk("pin_level", STSC_LVL_OFF, {29'h0, lvl});
    hw_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(ADR_SCROLL_DEF0, q);
    chk("def_rst", {7'h00, SCROLL_AREA_RST, 7'h00, TOP_FIXED_RST}, q);
  endtask : t_pin_reset
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_tear_mode1();
    t_tear_mode2();
    t_scroll_map();
    t_tear_off();
    t_power();
    t_bus();
    t_pin_reset();
    stop_test();
  end
endmodule : tb_top
bind stsc_top stsc_asserts stsc_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .tear_sync_o(tear_sync_o), .refresh_o(refresh_o),
  .panel_row_o(panel_row_o), .mem_row_o(mem_row_o), .color_reduce_o(color_reduce_o),
  .osc_run_o(osc_run_o), .blank_o(blank_o), .power_level_o(power_level_o));
